// >>> src/pld_macrocell_array.sv
// macrocell array fabric: routing matrix, product terms, expanders
// and configurable registers, evaluated frame by frame on hclk.
// assumes an ahb-lite master and pins asynchronous to hclk.
`timescale 1ns/1ps
//
// Contract
// - four dedicated inputs: logic inputs or clock, clear, two enables
// - macrocells grouped by 16, fed from routing matrix and globals
// - each macrocell registered or combinatorial, bypassing register
// - five terms each, steered to or/xor or register controls
// - register type d, t, jk or sr per macrocell
// - clock: global, global with enable, or array term clock
// - small variant one clock pin; enhanced two selectable clocks
// - term preset and clear active high and asynchronous
// - clear optionally from active-low global clear, per register
// - every register starts at zero
// - enhanced: pin path straight to register d input
// - sixteen shareable inverted terms per group, usable by all
// - own five plus up to three borrowed sets of five terms
// - borrow within chains of eight from lower neighbours only
// - signal enters group only when its enable cell is set
// - routing delay identical for every source and destination
module pld_macrocell_array
    import pld_fabric_pkg::*;
#(
    parameter bit ENHANCED = 1'b1
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    input  wire logic              global_clock_pin_one,
    input  wire logic              global_clock_pin_two,
    input  wire logic              global_clear_low,
    input  wire logic [1:0]        global_oe_pin,
    input  wire logic [NUM_IO-1:0] io_pin_in,
    output logic      [NUM_MC-1:0] mc_out,
    output logic      [1:0]        global_oe
);
    typedef struct packed {
        st_t                         st;
        logic [MEM_AW:0]             raddr;
        logic                        rvalid;
        logic [MEM_AW-1:0]           daddr;
        logic                        acc;
        logic [NUM_MC*SLOTS-1:0]     term;
        logic [NUM_MC-1:0]           shx;
        logic [NUM_MC-1:0]           q;
        logic [NUM_MC-1:0]           out;
        logic [NUM_MC-1:0]           aclk;
        logic [1:0]                  gprev;
        logic [1:0]                  gsticky;
        logic [1:0]                  gframe;
        logic [NUM_SIG-1:0]          snap;
        logic                        wr_pend;
        logic [HADDR_W-1:0]          waddr;
        logic [31:0]                 rdata;
        logic [CTRL_W-1:0]           ctrl;
        logic [GROUPS*ROUTE_W-1:0]   route;
        logic [NUM_MC*MCFG_W-1:0]    mcfg;
    } fab_t;

    fab_t              s_ff;
    fab_t              nxt_s;
    logic [PIN_W-1:0]  pin_q;
    logic [31:0]       mem_rdata;
    logic              mem_we;
    logic [MEM_AW-1:0] mem_waddr;
    logic              locked;
    logic [1:0]        gclk_now;
    logic [NUM_LIT-1:0] lit [GROUPS];
    logic [NUM_MC-1:0] q_apply;
    logic [NUM_MC-1:0] out_apply;
    logic [NUM_MC-1:0] aclk_now;

    function automatic logic chunk_ok(input logic [31:0] w,
                                      input logic [15:0] l);
        logic ok;
        ok = 1'b1;
        // bit 2i asks for the true literal, bit 2i+1 for its complement
        for (int i = 0; i < LIT_PER_CHUNK; i++) begin
            ok = ok & ~(w[2*i] & ~l[i]) & ~(w[2*i+1] & l[i]);
        end
        return ok;
    endfunction

    function automatic logic in_region(input logic [HADDR_W-1:0] a,
                                       input logic [HADDR_W-1:0] base,
                                       input int words);
        return (a >= base) && (int'(a) < int'(base) + 4 * words)
               && (a[1:0] == 2'h0);
    endfunction

    function automatic int word_idx(input logic [HADDR_W-1:0] a,
                                    input logic [HADDR_W-1:0] base);
        return int'((a - base) >> 2);
    endfunction

    pin_sync #(
        .W (PIN_W)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({io_pin_in, global_clock_pin_two, global_oe_pin,
                   global_clear_low, global_clock_pin_one}),
        .q       (pin_q)
    );

    term_mem #(
        .AW (MEM_AW),
        .DW (32)
    ) u_mem (
        .hclk    (hclk),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (hwdata),
        .rd_addr (s_ff.raddr[MEM_AW-1:0]),
        .rd_data (mem_rdata)
    );

    assign locked = s_ff.ctrl[CTRL_RUN] | (s_ff.st != ST_IDLE);
    assign mem_we = s_ff.wr_pend & ~locked
                    & in_region(s_ff.waddr, TERM_BASE, MEM_WORDS);
    assign mem_waddr = MEM_AW'(word_idx(s_ff.waddr, TERM_BASE));

    // two global clocks; the small variant only has the first pin
    always_comb begin
        gclk_now[0] = pin_q[DED_GCLK];
        gclk_now[1] = pin_q[DED_GCLK];
        if (ENHANCED) begin
            gclk_now[0] = (s_ff.ctrl[CTRL_SEL0] ? pin_q[PIN_GLOBAL_CLOCK_PIN_TWO]
                          : pin_q[DED_GCLK]) ^ s_ff.ctrl[CTRL_INV0];
            gclk_now[1] = (s_ff.ctrl[CTRL_SEL1] ? pin_q[PIN_GLOBAL_CLOCK_PIN_TWO]
                          : pin_q[DED_GCLK]) ^ s_ff.ctrl[CTRL_INV1];
        end
    end

    // literals seen by a group: enabled matrix signals plus own expanders
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            lit[g] = {{LIT_PAD{1'b0}},
                      ~s_ff.shx[g*MC_PER_GROUP +: MC_PER_GROUP],
                      s_ff.snap & s_ff.route[g*ROUTE_W +: NUM_SIG]};
        end
    end

    // next register and output values of every macrocell for one frame
    always_comb begin
        logic [MCFG_W-1:0]       c;
        logic [TERMS_PER_MC-1:0] t;
        logic [TERMS_PER_MC-1:0] sec;
        logic [TERMS_PER_MC-1:0] prim;
        logic [NUM_MC-1:0]       set_or;
        logic [NUM_MC-1:0]       lend_ok;
        logic own;
        logic bor;
        logic lg;
        logic d;
        logic kr;
        logic clr;
        logic pre;
        logic ev;
        logic qn;
        int   pos;
        c = '0; t = '0; sec = '0; prim = '0; set_or = '0; lend_ok = '0;
        own = 1'b0; bor = 1'b0; lg = 1'b0; d = 1'b0; kr = 1'b0;
        clr = 1'b0; pre = 1'b0; ev = 1'b0; qn = 1'b0; pos = 0;
        q_apply = '0; out_apply = '0; aclk_now = '0;
        for (int m = 0; m < NUM_MC; m++) begin
            c    = s_ff.mcfg[m*MCFG_W +: MCFG_W];
            t    = s_ff.term[m*SLOTS +: TERMS_PER_MC];
            sec  = c[MC_ROUTE_LSB +: TERMS_PER_MC];
            prim = t & ~sec;
            if (c[MC_TYPE_LSB +: 2] == FF_JK || c[MC_TYPE_LSB +: 2] == FF_SR)
            begin
                prim[KR_TERM] = 1'b0;
            end
            set_or[m]  = |prim;
            // top of a chain never lends
            lend_ok[m] = c[MC_LEND] && (m % CHAIN_LEN != CHAIN_LEN - 1);
        end
        for (int m = 0; m < NUM_MC; m++) begin
            c   = s_ff.mcfg[m*MCFG_W +: MCFG_W];
            t   = s_ff.term[m*SLOTS +: TERMS_PER_MC];
            sec = c[MC_ROUTE_LSB +: TERMS_PER_MC];
            pos = m % CHAIN_LEN;
            own = lend_ok[m] ? 1'b0 : set_or[m];
            bor = 1'b0;
            for (int j = 1; j <= MAX_SETS; j++) begin
                if (j <= pos && j <= int'(c[MC_BORROW_LSB +: 2])) begin
                    bor = bor | (set_or[m-j] & lend_ok[m-j]);
                end
            end
            lg  = (own | bor) ^ c[MC_INV];
            d   = (ENHANCED && c[MC_FAST])
                  ? s_ff.snap[NUM_DED + m % NUM_IO] : lg;
            kr  = t[KR_TERM] & ~sec[KR_TERM];
            clr = (t[SEC_CLR] & sec[SEC_CLR])
                  | (c[MC_GCLR] & ~s_ff.snap[DED_GCLR]);
            pre = t[SEC_PRE] & sec[SEC_PRE];
            aclk_now[m] = t[SEC_ACLK] & sec[SEC_ACLK];
            case (c[MC_CLK_LSB +: 2])
                CLK_GLOBAL:    ev = s_ff.gframe[ENHANCED & c[MC_GSEL]];
                CLK_GLOBAL_CE: ev = s_ff.gframe[ENHANCED & c[MC_GSEL]]
                                    & t[SEC_CE] & sec[SEC_CE];
                CLK_ARRAY:     ev = aclk_now[m] & ~s_ff.aclk[m];
                default:       ev = 1'b0;
            endcase
            qn = s_ff.q[m];
            // clear wins over preset when both are asserted
            if (clr) begin
                qn = 1'b0;
            end else if (pre) begin
                qn = 1'b1;
            end else if (ev) begin
                case (c[MC_TYPE_LSB +: 2])
                    FF_D:    qn = d;
                    FF_T:    qn = s_ff.q[m] ^ d;
                    FF_JK:   qn = (d & ~s_ff.q[m]) | (~kr & s_ff.q[m]);
                    FF_SR:   qn = (d & ~kr) ? 1'b1
                                  : ((kr & ~d) ? 1'b0 : s_ff.q[m]);
                    default: qn = s_ff.q[m];
                endcase
            end
            q_apply[m]   = qn;
            out_apply[m] = c[MC_REG] ? qn : lg;
        end
    end

    always_comb begin
        logic [HADDR_W-1:0] a;
        logic               grp;
        logic [CHUNK_BITS-1:0] ck;
        logic               acc_now;
        int                 wi;
        a = haddr[HADDR_W-1:0];
        grp = 1'b0; ck = '0; acc_now = 1'b0; wi = 0;
        nxt_s = s_ff;
        nxt_s.gprev = gclk_now;
        nxt_s.gsticky = (s_ff.st == ST_SNAP) ? 2'h0
                        : (s_ff.gsticky | (gclk_now & ~s_ff.gprev));
        case (s_ff.st)
            ST_IDLE: begin
                if (s_ff.ctrl[CTRL_RUN]) begin
                    nxt_s.q    = '0;
                    nxt_s.out  = '0;
                    nxt_s.aclk = '0;
                    nxt_s.shx  = '0;
                    nxt_s.st   = ST_SNAP;
                end
            end
            ST_SNAP: begin
                // one snapshot per frame gives every path the same delay
                nxt_s.snap = {s_ff.out, pin_q[PIN_IO +: NUM_IO],
                              pin_q[NUM_DED-1:0]};
                nxt_s.gframe = s_ff.gsticky | (gclk_now & ~s_ff.gprev);
                nxt_s.raddr  = '0;
                nxt_s.rvalid = 1'b0;
                nxt_s.st     = ST_EVAL;
            end
            ST_EVAL: begin
                if (!s_ff.raddr[MEM_AW]) begin
                    nxt_s.raddr = (MEM_AW+1)'(s_ff.raddr + 1'b1);
                end
                nxt_s.rvalid = ~s_ff.raddr[MEM_AW];
                nxt_s.daddr  = s_ff.raddr[MEM_AW-1:0];
                if (s_ff.rvalid) begin
                    ck  = s_ff.daddr[CHUNK_BITS-1:0];
                    grp = s_ff.daddr[MEM_AW-1];
                    acc_now = ((ck == '0) ? 1'b1 : s_ff.acc)
                              & chunk_ok(mem_rdata,
                                lit[grp][ck*LIT_PER_CHUNK +: LIT_PER_CHUNK]);
                    nxt_s.acc = acc_now;
                    if (&ck) begin
                        nxt_s.term[s_ff.daddr[MEM_AW-1:CHUNK_BITS]] = acc_now;
                    end
                    if (&s_ff.daddr) begin
                        nxt_s.st = ST_APPLY;
                    end
                end
            end
            ST_APPLY: begin
                nxt_s.q    = q_apply;
                nxt_s.out  = out_apply;
                nxt_s.aclk = aclk_now;
                for (int m = 0; m < NUM_MC; m++) begin
                    nxt_s.shx[m] = s_ff.term[m*SLOTS + SHARE_SLOT];
                end
                nxt_s.st = s_ff.ctrl[CTRL_RUN] ? ST_SNAP : ST_IDLE;
            end
            default: nxt_s.st = ST_IDLE;
        endcase

        // bus data phase: writes land here, one cycle after the address
        if (s_ff.wr_pend) begin
            if (s_ff.waddr == CTRL_OFS) begin
                nxt_s.ctrl = hwdata[CTRL_W-1:0];
            end else if (!locked) begin
                if (in_region(s_ff.waddr, ROUTE_BASE, ROUTE_WORDS)) begin
                    wi = word_idx(s_ff.waddr, ROUTE_BASE);
                    nxt_s.route[wi*32 +: 32] = hwdata;
                end
                if (in_region(s_ff.waddr, MCFG_BASE, NUM_MC)) begin
                    wi = word_idx(s_ff.waddr, MCFG_BASE);
                    nxt_s.mcfg[wi*MCFG_W +: MCFG_W] = hwdata[MCFG_W-1:0];
                end
            end
        end

        // bus address phase: reads are answered from a register
        nxt_s.wr_pend = hsel & hready & htrans[1] & hwrite;
        nxt_s.waddr   = a;
        nxt_s.rdata   = 32'h0;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (a == CTRL_OFS) begin
                nxt_s.rdata = 32'(s_ff.ctrl);
            end else if (a == STATUS_OFS) begin
                nxt_s.rdata = 32'({locked, s_ff.st});
            end else if (a == OUT_OFS) begin
                nxt_s.rdata = 32'(s_ff.out);
            end else if (in_region(a, ROUTE_BASE, ROUTE_WORDS)) begin
                wi = word_idx(a, ROUTE_BASE);
                nxt_s.rdata = s_ff.route[wi*32 +: 32];
            end else if (in_region(a, MCFG_BASE, NUM_MC)) begin
                wi = word_idx(a, MCFG_BASE);
                nxt_s.rdata = 32'(s_ff.mcfg[wi*MCFG_W +: MCFG_W]);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff    <= '0;
            s_ff.st <= ST_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_ff.rdata;
    assign mc_out    = s_ff.out;
    assign global_oe = pin_q[DED_OE +: 2];
endmodule // pld_macrocell_array

// >>> pkg/pld_fabric_pkg.sv
// constants, field layouts and types of the macrocell array fabric
// assumes one hclk domain; registers reached over ahb-lite
package pld_fabric_pkg;
    localparam int GROUPS       = 2;
    localparam int MC_PER_GROUP = 16;
    localparam int NUM_MC       = GROUPS * MC_PER_GROUP;
    localparam int NUM_IO       = 16;
    localparam int NUM_DED      = 4;
    localparam int NUM_SIG      = NUM_DED + NUM_IO + NUM_MC;
    localparam int CHAIN_LEN    = 8;
    localparam int TERMS_PER_MC = 5;
    localparam int MAX_SETS     = 3;
    localparam int SLOTS        = 8;
    localparam int SLOT_BITS    = 3;
    localparam int SHARE_SLOT   = 5;
    localparam int LIT_PER_CHUNK = 16;
    localparam int CHUNKS       = 8;
    localparam int CHUNK_BITS   = 3;
    localparam int NUM_LIT      = CHUNKS * LIT_PER_CHUNK;
    localparam int LIT_PAD      = NUM_LIT - NUM_SIG - MC_PER_GROUP;
    localparam int MEM_AW       = 11;
    localparam int MEM_WORDS    = NUM_MC * SLOTS * CHUNKS;
    localparam int ROUTE_W      = 64;
    localparam int ROUTE_WORDS  = GROUPS * ROUTE_W / 32;
    localparam int HADDR_W      = 14;
    // dedicated input positions in the routed signal vector, then the PIN_ positions in the synchronised pin vector
    localparam int DED_GCLK = 0;
    localparam int DED_GCLR = 1;
    localparam int DED_OE   = 2;
    localparam int PIN_GLOBAL_CLOCK_PIN_TWO = 4;
    localparam int PIN_IO    = 5;
    localparam int PIN_W     = PIN_IO + NUM_IO;
    // byte offsets
    localparam logic [HADDR_W-1:0] CTRL_OFS   = 14'h0000;
    localparam logic [HADDR_W-1:0] STATUS_OFS = 14'h0004;
    localparam logic [HADDR_W-1:0] OUT_OFS    = 14'h0008;
    localparam logic [HADDR_W-1:0] ROUTE_BASE = 14'h0100;
    localparam logic [HADDR_W-1:0] MCFG_BASE  = 14'h0200;
    localparam logic [HADDR_W-1:0] TERM_BASE  = 14'h2000;
    // control register bits
    localparam int CTRL_RUN  = 0;
    localparam int CTRL_INV0 = 1;
    localparam int CTRL_SEL0 = 2;
    localparam int CTRL_INV1 = 3;
    localparam int CTRL_SEL1 = 4;
    localparam int CTRL_W    = 5;
    // per macrocell configuration word
    localparam int MC_REG        = 0;
    localparam int MC_TYPE_LSB   = 1;
    localparam int MC_CLK_LSB    = 3;
    localparam int MC_GSEL       = 5;
    localparam int MC_ROUTE_LSB  = 6;
    localparam int MC_GCLR       = 11;
    localparam int MC_BORROW_LSB = 12;
    localparam int MC_LEND       = 14;
    localparam int MC_INV        = 15;
    localparam int MC_FAST       = 16;
    localparam int MCFG_W        = 17;
    // secondary role of a term that is steered away from the or gate
    localparam int SEC_CLR  = 0;
    localparam int SEC_PRE  = 1;
    localparam int SEC_ACLK = 2;
    localparam int SEC_CE   = 3;
    localparam int KR_TERM  = 4;

    typedef enum logic [1:0] {
        FF_D  = 2'h0,
        FF_T  = 2'h1,
        FF_JK = 2'h2,
        FF_SR = 2'h3
    } ff_t;

    typedef enum logic [1:0] {
        CLK_GLOBAL    = 2'h0,
        CLK_GLOBAL_CE = 2'h1,
        CLK_ARRAY     = 2'h2
    } clk_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SNAP  = 4'h2,
        ST_EVAL  = 4'h4,
        ST_APPLY = 4'h8
    } st_t;
endpackage

// >>> src/pin_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
// assumes levels only; a pulse shorter than one clock can be missed
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t s_ff;
    sync_t nxt_s;

    always_comb begin
        nxt_s    = s_ff;
        nxt_s.s1 = d;
        nxt_s.s2 = s_ff.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.s2;
endmodule // pin_sync

// >>> src/term_mem.sv
// product-term mask memory, one write port, one registered read port
// assumes writer and reader never touch it in the same frame
`timescale 1ns/1ps
module term_mem #(
    parameter int AW = 11,
    parameter int DW = 32
) (
    input  wire logic          hclk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [2**AW];

    // no reset: contents are configuration loaded by software
    always_ff @(posedge hclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // term_mem

// >>> tb/pld_macrocell_array_chk.sv
// port-level checks of the macrocell array fabric
// assumes one hclk domain and a single ahb-lite slave on the bus
`timescale 1ns/1ps
module pld_macrocell_array_chk
    import pld_fabric_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic [31:0]       hrdata,
    input wire logic [1:0]        global_oe_pin,
    input wire logic [NUM_MC-1:0] mc_out,
    input wire logic [1:0]        global_oe
);
    logic               rd_dp_ff;
    logic [HADDR_W-1:0] adr_ff;

    // remembers which read is in its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp_ff <= 1'b0;
            adr_ff   <= '0;
        end else begin
            rd_dp_ff <= hsel && hready && htrans[1] && !hwrite;
            adr_ff   <= haddr[HADDR_W-1:0];
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("slave gave an error response");
    idle_data_zero_a: assert property (
        !rd_dp_ff |-> hrdata == '0)
        else $error("read data outside a read data phase");
    reset_out_zero_a: assert property (
        $rose(hresetn) |-> mc_out == '0)
        else $error("macrocell output not zero after reset");
    oe_follow_a: assert property ($past(hresetn, 3) |->
        global_oe == $past(global_oe_pin, 2))
        else $error("global enable does not follow its pin");
    frame_hold_a: assert property ($changed(mc_out) |=>
        $stable(mc_out)[*8])
        else $error("macrocell output changed inside a frame");
    out_read_a: assert property (rd_dp_ff && adr_ff == OUT_OFS |->
        hrdata == $past(mc_out))
        else $error("output register read differs from outputs");
    status_read_a: assert property (
        rd_dp_ff && adr_ff == STATUS_OFS |->
        $onehot(hrdata[3:0]) && hrdata[31:5] == '0)
        else $error("status state field not one-hot");
endmodule // pld_macrocell_array_chk

bind pld_macrocell_array pld_macrocell_array_chk chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .global_oe_pin(global_oe_pin), .mc_out(mc_out),
    .global_oe(global_oe)
);

// >>> tb/pld_macrocell_array_tb.sv
// self-checking bench of the macrocell array fabric
// assumes zero-wait ahb-lite slave and frames of about 2052 cycles
`timescale 1ns/1ps
module pld_macrocell_array_tb
    import pld_fabric_pkg::*;
;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic              clear_low;
    logic [31:0]       haddr, hwdata, hrdata, rd_q, v;
    logic [1:0]        htrans, oe_pin, global_oe;
    logic [15:0]       io_in;
    logic [3:0]        div_ff;
    logic [NUM_MC-1:0] mc_out;
    int                error_cnt, n_compared;

    pld_macrocell_array dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata),
        .global_clock_pin_one(div_ff[3]), .global_clock_pin_two(div_ff[2]),
        .global_clear_low(clear_low), .global_oe_pin(oe_pin),
        .io_pin_in(io_in), .mc_out(mc_out), .global_oe(global_oe)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // pin clocks toggle slowly so every frame sees edges
    always @(posedge hclk) begin
        if (!hresetn) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
        rd_q <= hrdata;
    end

    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // read data is taken from the copy sampled at the closing edge
    task automatic bus(input logic w, input logic [13:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {18'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        @(negedge hclk);
        rd = rd_q;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask

    task automatic pins(input logic [15:0] io, input logic clr,
                        input logic [1:0] oe, input int wait_cyc);
        @(posedge hclk);
        io_in     <= io;
        clear_low <= clr;
        oe_pin    <= oe;
        repeat (wait_cyc) @(posedge hclk);
    endtask

    task automatic t_reset;
        bus(1'b0, CTRL_OFS, 32'h0, v);
        check("ctrl", v, 32'h0);
        bus(1'b0, STATUS_OFS, 32'h0, v);
        check("status", v, 32'h1);
        bus(1'b0, OUT_OFS, 32'h0, v);
        check("out", v, 32'h0);
        bus(1'b0, 14'h000c, 32'h0, v);
        check("hole", v, 32'h0);
        wr(CTRL_OFS, 32'h1e);
        bus(1'b0, CTRL_OFS, 32'h0, v);
        check("clk sel", v, 32'h1e);
        wr(CTRL_OFS, 32'h0);
    endtask

    // term memory has no reset, so every mask is cleared first
    task automatic t_fill;
        for (int i = 0; i < MEM_WORDS; i++) begin
            wr(TERM_BASE + 14'(i * 4), 32'h0);
        end
        bus(1'b0, TERM_BASE, 32'h0, v);
        check("term rd", v, 32'h0);
    endtask

    task automatic t_fabric;
        wr(ROUTE_BASE, 32'h10);
        bus(1'b0, ROUTE_BASE, 32'h0, v);
        check("route", v, 32'h10);
        wr(TERM_BASE, 32'h100);
        // mc11 term0 needs the inverted shared term of mc0, which is false from the second frame on, so mc11 is high only after the first frame
        wr(TERM_BASE + 14'h0b0c, 32'h100);
        wr(MCFG_BASE, 32'h780);
        wr(MCFG_BASE + 14'h4, 32'h801);
        wr(MCFG_BASE + 14'h8, 32'h8000);
        wr(MCFG_BASE + 14'h10, 32'h10001);
        wr(MCFG_BASE + 14'h14, 32'h7);
        wr(MCFG_BASE + 14'h18, 32'h405);
        wr(MCFG_BASE + 14'h1c, 32'h881);
        wr(MCFG_BASE + 14'h20, 32'h37c0);
        wr(MCFG_BASE + 14'h24, 32'h4000);
        wr(MCFG_BASE + 14'h28, 32'h17c0);
        wr(MCFG_BASE + 14'h2c, 32'h780);
        wr(MCFG_BASE + 14'h3c, 32'h4000);
        bus(1'b0, MCFG_BASE + 14'h10, 32'h0, v);
        check("mcfg", v, 32'h10001);
        pins(16'h0011, 1'b1, 2'h2, 0);
        wr(CTRL_OFS, 32'h1);
        wr(ROUTE_BASE, 32'h0);
        bus(1'b0, ROUTE_BASE, 32'h0, v);
        check("locked", v, 32'h10);
        check("oe", {30'h0, global_oe}, 32'h2);
        pins(16'h0011, 1'b1, 2'h2, 6300);
        bus(1'b0, OUT_OFS, 32'h0, v);
        check("out high", {16'h0, v[15:0]}, 32'hf4db);
        pins(16'h0000, 1'b0, 2'h1, 6300);
        bus(1'b0, OUT_OFS, 32'h0, v);
        check("out clear", {16'h0, v[15:0]}, 32'hf448);
        check("oe two", {30'h0, global_oe}, 32'h1);
    endtask

    task automatic t_route_off;
        int n;
        wr(CTRL_OFS, 32'h0);
        n = 0;
        do begin
            bus(1'b0, STATUS_OFS, 32'h0, v);
            n++;
        end while (v[4] !== 1'b0 && n < 1000);
        check("unlocked", {27'h0, v[4:0]}, 32'h01);
        wr(ROUTE_BASE, 32'h0);
        wr(CTRL_OFS, 32'h1);
        pins(16'h0001, 1'b1, 2'h0, 6300);
        bus(1'b0, OUT_OFS, 32'h0, v);
        check("no route", {31'h0, v[0]}, 32'h0);
    endtask

    initial begin
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hwdata     = 32'h0;
        clear_low  = 1'b1;
        oe_pin     = 2'h0;
        io_in      = 16'h0;
        error_cnt  = 0;
        n_compared = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_fill;
        t_fabric;
        t_route_off;
        stop_test;
    end

    // about four times the expected run length
    initial begin
        #400000;
        error_cnt++;
        stop_test;
    end
endmodule // pld_macrocell_array_tb
